// [src/sld_top.sv]
// Purpose: serial-in latched sink driver, twelve open-drain sink channels
// Assumes: host pins are asynchronous and are oversampled on clk_sys
// Notes: host edges must be at least three clk_sys periods apart
//
// How it works
// - each rising shift clock shifts the register and takes serial in at stage 0
// - last stage goes to serial out on the falling shift clock
// - each rising latch clock with room in the buffer queues all twelve stages for the storage latch
// - clear low zeroes shift register, storage latch and buffer
// - latch contents reach the output buffer only while clear is high
// - enable low drives each channel from its storage latch bit
// - enable high turns all channels off, storage latch still takes queued words
// - twelve independent channels zero to eleven, one latch bit each
// - output bit one sinks current, bit zero leaves channel off
`timescale 1ns/10ps
module sld_top #(
  parameter int unsigned CHANNELS = sld_pkg::CHANNELS,
  parameter int unsigned BUF_DEPTH = sld_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,  // 10 MHz system clock
  input wire logic resetn,  // async reset, active low
  input wire logic shift_clock,  // host shift clock pin
  input wire logic latch_clock,  // host latch clock pin
  input wire logic clear_n,  // host clear pin, active low
  input wire logic serial_in,  // serial data pin
  input wire logic out_enable_n,  // channel enable pin, active low
  input wire logic update_ready,  // output stage may take a new word
  output logic serial_out,  // cascade data pin
  output logic [CHANNELS-1:0] sink_channel_o,  // drain pin drive level
  output logic [CHANNELS-1:0] sink_channel_oe,  // drain pin sinking when high
  output logic latch_stall  // buffer full, latch edges would be lost
);
  generate
    if (CHANNELS != sld_pkg::CHANNELS) begin : g_bad_width
      $error("sld_top is built for twelve channels only");
    end
  endgenerate

  // reset release through two flops
  logic rst_s1_r, rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // pin synchroniser; stage one is read only by stage two
  // a third flop feeds the edge detectors, hence the three-period pin minimum
  sld_pkg::sld_pins_t pin_raw, pin_s1_r, pin_s2_r, pin_d_r;
  assign pin_raw = '{
    shift_clock: shift_clock, latch_clock: latch_clock, clear_n: clear_n,
    serial_in: serial_in, out_enable_n: out_enable_n
  };
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= sld_pkg::PINS_IDLE;
      pin_s2_r <= sld_pkg::PINS_IDLE;
      pin_d_r <= sld_pkg::PINS_IDLE;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  logic shift_rise, shift_fall, latch_rise, clr_act;
  assign shift_rise = pin_s2_r.shift_clock && !pin_d_r.shift_clock;
  assign shift_fall = !pin_s2_r.shift_clock && pin_d_r.shift_clock;
  assign latch_rise = pin_s2_r.latch_clock && !pin_d_r.latch_clock;
  assign clr_act = !pin_s2_r.clear_n;

  // shift chain and cascade output
  logic [CHANNELS-1:0] shift_r, shift_nxt;
  logic serial_out_r, serial_out_nxt;
  always_comb begin
    shift_nxt = shift_r;
    serial_out_nxt = serial_out_r;
    if (clr_act) begin
      shift_nxt = sld_pkg::WORD_CLEAR;
      serial_out_nxt = 1'b0;
    end else begin
      if (shift_rise) begin
        shift_nxt = {shift_r[CHANNELS-2:0], pin_s2_r.serial_in};
      end
      if (shift_fall) begin
        serial_out_nxt = shift_r[sld_pkg::LAST_STAGE];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= sld_pkg::WORD_CLEAR;
      serial_out_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      serial_out_r <= serial_out_nxt;
    end
  end

  // latched words queue here so a stalled output stage loses none while the buffer has room
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [CHANNELS-1:0] buf_out_data;
  sld_buf #(.WIDTH(CHANNELS), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk_sys),
    .rst_n(rst_n),
    .flush(clr_act),
    .in_valid(latch_rise),
    .in_ready(buf_in_ready),
    .in_data(shift_r),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );
  // nothing passes while clear is low
  assign buf_pop = update_ready && !clr_act;

  // storage latch and channel drive
  logic [CHANNELS-1:0] store_r, store_nxt, oe_r, oe_nxt;
  // stall shows one cycle late; host pacing keeps latch edges far enough apart
  logic stall_r, stall_nxt;
  always_comb begin
    store_nxt = store_r;
    if (clr_act) begin
      store_nxt = sld_pkg::WORD_CLEAR;
    end else if (buf_out_valid && buf_pop) begin
      store_nxt = buf_out_data;
    end
    oe_nxt = pin_s2_r.out_enable_n ? sld_pkg::WORD_CLEAR : store_r;
    if (clr_act) begin
      oe_nxt = sld_pkg::WORD_CLEAR;
    end
    stall_nxt = !buf_in_ready;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store_r <= sld_pkg::WORD_CLEAR;
      oe_r <= sld_pkg::WORD_CLEAR;
      stall_r <= 1'b0;
    end else begin
      store_r <= store_nxt;
      oe_r <= oe_nxt;
      stall_r <= stall_nxt;
    end
  end

  // open-drain pins only ever pull low; the enable carries the data
  logic [CHANNELS-1:0] sink_lvl_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sink_lvl_r <= {CHANNELS{sld_pkg::SINK_LEVEL}};
    end else begin
      sink_lvl_r <= {CHANNELS{sld_pkg::SINK_LEVEL}};
    end
  end

  assign serial_out = serial_out_r;
  assign sink_channel_o = sink_lvl_r;
  assign sink_channel_oe = oe_r;
  assign latch_stall = stall_r;

  // checks; every property waits out reset through the synchronised copy
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_shift_edge;
    shift_rise && !clr_act;
  endsequence
  sequence s_latch_in;
    latch_rise && buf_in_ready && !clr_act;
  endsequence
  // a latch edge into an empty queue, then one cycle the output stage accepts
  sequence s_latch_first;
    latch_rise && !buf_out_valid && !clr_act;
  endsequence
  sequence s_drain_open;
    update_ready && !clr_act;
  endsequence

  a_shift_take: assert property (s_shift_edge |=>
    shift_r == {$past(shift_r[CHANNELS-2:0]), $past(pin_s2_r.serial_in)})
    else $error("shift chain did not take serial input");
  a_shift_idle: assert property (!shift_rise && !clr_act |=>
    $stable(shift_r)) else $error("shift chain moved without a rising edge");
  a_cascade_fall: assert property (shift_fall && !clr_act |=>
    serial_out == $past(shift_r[sld_pkg::LAST_STAGE]))
    else $error("serial out missed the falling edge");
  a_cascade_hold: assert property (!shift_fall && !clr_act |=>
    $stable(serial_out)) else $error("serial out moved without a falling edge");

  a_latch_queue: assert property (s_latch_in |=> buf_out_valid)
    else $error("latched word not queued");
  a_latch_copy: assert property (s_latch_first ##1 s_drain_open
    |=> store_r == $past(shift_r, 2)) else $error("latched word never reached storage");
  // storage only ever changes through a queued word or a clear
  a_store_hold: assert property (!(buf_out_valid && buf_pop) && !clr_act
    |=> $stable(store_r)) else $error("storage latch changed without a queued word");

  a_clear_all: assert property (clr_act |=> shift_r == '0 && store_r == '0
    && !buf_out_valid) else $error("clear left state behind");
  a_clear_fast: assert property (clr_act |=> sink_channel_oe == '0)
    else $error("channels still on after clear");
  a_clear_block: assert property (clr_act |=> ##1 sink_channel_oe == '0)
    else $error("channels active during clear");
  a_enable_drive: assert property (!pin_s2_r.out_enable_n && !clr_act
    |=> sink_channel_oe == $past(store_r)) else $error("channel does not follow latch");
  a_enable_off: assert property (pin_s2_r.out_enable_n && !clr_act
    |=> sink_channel_oe == '0 && (store_r == $past(store_r) || $past(buf_pop && buf_out_valid)))
    else $error("disabled channel sinking or latch disturbed");
  a_sink_level: assert property (sink_channel_o == '0)
    else $error("drain pin driven high");
endmodule : sld_top

// [src/sld_pkg.sv]
// Purpose: shared constants and carriers of the serial-in latched sink driver
// Assumes: one system clock, host pins asynchronous to it
// Notes: widths here are defaults; modules take them as parameters
package sld_pkg;
  localparam int unsigned CHANNELS = 12;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [CHANNELS-1:0] WORD_CLEAR = 12'h000;
  localparam logic SINK_LEVEL = 1'b0;
  localparam int unsigned LAST_STAGE = CHANNELS - 1;

  // host-side pin levels, carried together through the synchroniser
  typedef struct packed {
    logic shift_clock;
    logic latch_clock;
    logic clear_n;
    logic serial_in;
    logic out_enable_n;
  } sld_pins_t;

  localparam sld_pins_t PINS_IDLE = '{
    shift_clock: 1'b0, latch_clock: 1'b0, clear_n: 1'b0, serial_in: 1'b0, out_enable_n: 1'b1
  };
endpackage : sld_pkg

// [src/sld_buf.sv]
// Purpose: small word buffer with valid/ready on both sides
// Assumes: single clock, flush is synchronous
// Notes: in_ready is decoded from the registered count only, so fill side sees no comb path
`timescale 1ns/10ps
module sld_buf #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,  // system clock
  input wire logic rst_n,  // synchronised reset, active low
  input wire logic flush,  // drop all held words
  input wire logic in_valid,  // word offered
  output logic in_ready,  // room for a word
  input wire logic [WIDTH-1:0] in_data,  // word in
  output logic out_valid,  // word held
  input wire logic out_ready,  // drain side takes the word
  output logic [WIDTH-1:0] out_data  // oldest word
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  generate
    if (DEPTH < 2) begin : g_bad_depth
      $error("sld_buf needs DEPTH of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign in_ready = (cnt_r != CNT_FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      rd_nxt = '0;
      wr_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        mem_nxt[wr_r] = in_data;
        wr_nxt = ptr_inc(wr_r);
      end
      if (pop) begin
        rd_nxt = ptr_inc(rd_r);
      end
      if (push && !pop) begin
        cnt_nxt = cnt_r + CW'(1);
      end else if (pop && !push) begin
        cnt_nxt = cnt_r - CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_buf_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_r <= CNT_FULL) else $error("buffer count above depth");
endmodule : sld_buf

// [verif/sld_host.sv]
// Purpose: host model driving the pins of the sink driver
// Assumes: pins change just after a clk_sys rising edge
// Notes: 4-period phases keep above the 3-period minimum
`timescale 1ns/10ps
module sld_host (
  input wire logic clk_sys,  // system clock
  output logic shift_clock,  // shift clock pin
  output logic latch_clock,  // latch clock pin
  output logic clear_n,  // clear pin, active low
  output logic serial_in,  // serial data pin
  output logic out_enable_n  // enable pin, active low
);
  localparam int PHASE = 4;
  initial begin
    shift_clock = 1'b0;
    latch_clock = 1'b0;
    clear_n = 1'b0;
    serial_in = 1'b0;
    out_enable_n = 1'b1;
  end
  task automatic gap();
    repeat (PHASE) @(posedge clk_sys);
  endtask : gap
  task automatic shift_rise(input logic b);
    serial_in <= b;
    gap();
    shift_clock <= 1'b1;
    gap();
  endtask : shift_rise
  // data is flipped after the fall so a stale bit is never read twice
  task automatic shift_fall(input logic b);
    shift_clock <= 1'b0;
    repeat (PHASE / 2) @(posedge clk_sys);
    serial_in <= ~b;
    repeat (PHASE / 2) @(posedge clk_sys);
  endtask : shift_fall
  // twelve shifts, first bit lands on channel 11
  task automatic send_word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      shift_rise(w[i]);
      shift_fall(w[i]);
    end
  endtask : send_word
  // one stage here; clocks would be shared along a chain
  task automatic latch_pulse();
    latch_clock <= 1'b1;
    gap();
    latch_clock <= 1'b0;
    gap();
  endtask : latch_pulse
  task automatic set_levels(input logic clr_n, input logic en_n);
    clear_n <= clr_n;
    out_enable_n <= en_n;
    gap();
  endtask : set_levels
endmodule : sld_host

// [verif/sld_top_tb.sv]
// Purpose: self-checking bench of the sink driver top
// Assumes: host model drives pins, bench drives update_ready
// Notes: fixed waits follow the sync and buffer latencies
`timescale 1ns/10ps
module sld_top_tb;
  logic clk_sys, resetn, update_ready, serial_out, latch_stall;
  logic shift_clock, latch_clock, clear_n, serial_in, out_enable_n;
  logic [11:0] sink_channel_o, sink_channel_oe;
  int n_errors;
  int num_checks;
  sld_host u_host (.clk_sys(clk_sys), .shift_clock(shift_clock), .latch_clock(latch_clock),
    .clear_n(clear_n), .serial_in(serial_in), .out_enable_n(out_enable_n));
  sld_top uut (.clk_sys(clk_sys), .resetn(resetn), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .clear_n(clear_n), .serial_in(serial_in),
    .out_enable_n(out_enable_n), .update_ready(update_ready), .serial_out(serial_out),
    .sink_channel_o(sink_channel_o), .sink_channel_oe(sink_channel_oe),
    .latch_stall(latch_stall));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle
  task automatic load(input logic [11:0] w);
    u_host.send_word(w);
    u_host.latch_pulse();
    settle();
  endtask : load
  task automatic t_channels();
    for (int k = 0; k < 12; k++) begin
      load(12'h001 << k);
      check(sink_channel_oe, 12'h001 << k);
    end
    load(12'hA5C);
    check(sink_channel_oe, 12'hA5C);
    check(sink_channel_o, 12'h000);
  endtask : t_channels
  task automatic t_enable();
    u_host.set_levels(1'b1, 1'b1);
    settle();
    check(sink_channel_oe, 12'h000);
    u_host.set_levels(1'b1, 1'b0);
    settle();
    check(sink_channel_oe, 12'hA5C);
  endtask : t_enable
  task automatic t_serial();
    u_host.send_word(12'h801);
    settle();
    check({11'h000, serial_out}, 12'h001);
    u_host.shift_rise(1'b0);
    settle();
    check({11'h000, serial_out}, 12'h001);
    u_host.shift_fall(1'b0);
    settle();
    check({11'h000, serial_out}, 12'h000);
    u_host.latch_pulse();
    settle();
    check(sink_channel_oe, 12'h002);
  endtask : t_serial
  task automatic t_clear();
    u_host.set_levels(1'b0, 1'b0);
    settle();
    check(sink_channel_oe, 12'h000);
    load(12'hFFF);
    check(sink_channel_oe, 12'h000);
    u_host.set_levels(1'b1, 1'b0);
    u_host.latch_pulse();
    settle();
    check(sink_channel_oe, 12'h000);
  endtask : t_clear
  task automatic t_buffer();
    @(posedge clk_sys);
    update_ready <= 1'b0;
    load(12'h111);
    load(12'h222);
    check({11'h000, latch_stall}, 12'h001);
    load(12'h333);
    @(posedge clk_sys);
    update_ready <= 1'b1;
    settle();
    check(sink_channel_oe, 12'h222);
    check({11'h000, latch_stall}, 12'h000);
  endtask : t_buffer
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    n_errors = 0;
    num_checks = 0;
    resetn = 1'b0;
    update_ready = 1'b1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    u_host.set_levels(1'b1, 1'b0);
    t_channels();
    t_enable();
    t_serial();
    t_clear();
    t_buffer();
    end_of_test();
  end
  // run needs about 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
endmodule : sld_top_tb
